// *** hw/rrx_exec.sv ***
// return and rotate execution block with an axi4-lite register port
// assumes data memory answers mem_rdata in the same cycle as mem_re,
// and the return stack head is a same-clock signal
`timescale 1ns/1ps
`include "rrx_cfg.svh"
module rrx_exec (
  input wire logic clk, // 25 MHz core clock
  input wire logic rst_b, // async reset, active low
  input rrx_pkg::rrx_axi_req_s axi_req, // axi4-lite master side
  output rrx_pkg::rrx_axi_rsp_s axi_rsp, // axi4-lite slave side
  input wire logic [20:0] return_stack_head, // current stack top
  output logic stack_pop, // one-cycle pop strobe
  output rrx_pkg::rrx_mem_s mem, // data memory request
  input wire logic [7:0] mem_rdata // data memory read byte
);
  import rrx_pkg::*;

  rrx_state_s st_r;
  rrx_state_s nxt;
  logic [7:0] rot_res;
  logic rot_cout;
  logic wr_go;
  logic is_rot;
  logic go;
  rrx_kind_e dec;

  ////////////////////////////////////////////////////////////////////////
  function automatic rrx_kind_e rrx_decode(input logic [15:0] i);
    rrx_kind_e k;
    k = RRX_K_NONE;
    if (i[15:1] == `RRX_OP_RET_HI) begin
      k = RRX_K_RET;
    end else begin
      case (i[15:10])
        `RRX_OP_RLC: k = RRX_K_RLC;
        `RRX_OP_RLN: k = RRX_K_RLN;
        `RRX_OP_RRC: k = RRX_K_RRC;
        `RRX_OP_RRN: k = RRX_K_RRN;
        default: k = RRX_K_NONE;
      endcase
    end
    return k;
  endfunction

  function automatic logic [31:0] rrx_merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic rrx_is_rot(input rrx_kind_e k);
    return (k == RRX_K_RLC) || (k == RRX_K_RLN) || (k == RRX_K_RRC) || (k == RRX_K_RRN);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  rrx_rotate u_rot (
    .opnd(st_r.opnd),
    .carry_in(st_r.flags[`RRX_FLG_C]),
    .kind(st_r.kind),
    .result(rot_res),
    .carry_out(rot_cout)
  );

  assign is_rot = rrx_is_rot(st_r.kind);
  assign dec = rrx_decode(st_r.instr);
  assign wr_go = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign stack_pop = st_r.pop;
  assign mem = st_r.mem;

  always_comb begin
    axi_rsp.awready = !st_r.aw_got && !st_r.bvalid;
    axi_rsp.wready = !st_r.w_got && !st_r.bvalid;
    axi_rsp.bvalid = st_r.bvalid;
    axi_rsp.bresp = st_r.bresp;
    axi_rsp.arready = !st_r.rvalid;
    axi_rsp.rvalid = st_r.rvalid;
    axi_rsp.rdata = st_r.rdata;
    axi_rsp.rresp = st_r.rresp;
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [31:0] m;
    logic [31:0] rd;
    m = `RRX_RST_WORD;
    rd = `RRX_RST_WORD;
    nxt = st_r;
    nxt.pop = 1'b0;
    go = 1'b0;
    // bus write channels, taken in either order
    if (axi_req.awvalid && axi_rsp.awready) begin
      nxt.aw_got = 1'b1;
      nxt.aw_a = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      nxt.w_got = 1'b1;
      nxt.w_d = axi_req.wdata;
      nxt.w_s = axi_req.wstrb;
    end
    if (st_r.bvalid && axi_req.bready) begin
      nxt.bvalid = 1'b0;
    end
    if (wr_go) begin
      nxt.aw_got = 1'b0;
      nxt.w_got = 1'b0;
      nxt.bvalid = 1'b1;
      nxt.bresp = `RRX_RESP_OKAY;
      // refusing writes while busy keeps bus and core off the same registers
      if (st_r.aw_a == `RRX_CTRL_OFS) begin
        go = st_r.w_s[0] && st_r.w_d[`RRX_CTRL_START] && (st_r.phase == RRX_IDLE);
      end else if (st_r.phase != RRX_IDLE) begin
        nxt.bresp = `RRX_RESP_SLVERR;
      end else begin
        case (st_r.aw_a)
          `RRX_INSTR_OFS: begin
            m = rrx_merge({16'h0000, st_r.instr}, st_r.w_d, st_r.w_s);
            nxt.instr = m[15:0];
          end
          `RRX_ACC_OFS: begin
            m = rrx_merge({24'h00_0000, st_r.w}, st_r.w_d, st_r.w_s);
            nxt.w = m[7:0];
          end
          `RRX_FLAGS_OFS: begin
            m = rrx_merge({27'h000_0000, st_r.flags}, st_r.w_d, st_r.w_s);
            nxt.flags = m[4:0];
          end
          `RRX_BANK_OFS: begin
            m = rrx_merge({28'h000_0000, st_r.bank}, st_r.w_d, st_r.w_s);
            nxt.bank = m[3:0];
          end
          `RRX_SHADOW_OFS: begin
            m = rrx_merge({12'h000, st_r.bnkc, 3'h0, st_r.flgc, st_r.accc}, st_r.w_d, st_r.w_s);
            nxt.accc = m[7:0];
            nxt.flgc = m[`RRX_SHD_FLG_LSB +: 5];
            nxt.bnkc = m[`RRX_SHD_BNK_LSB +: 4];
          end
          `RRX_PC_OFS: begin
            m = rrx_merge({11'h000, st_r.pc}, st_r.w_d, st_r.w_s);
            nxt.pc = m[20:0];
          end
          `RRX_LATCH_OFS: begin
            m = rrx_merge({19'h0_0000, st_r.latu, st_r.lath}, st_r.w_d, st_r.w_s);
            nxt.lath = m[7:0];
            nxt.latu = m[`RRX_LAT_UP_LSB +: 5];
          end
          `RRX_RESULT_OFS: nxt.bresp = `RRX_RESP_SLVERR;
          default: nxt.bresp = `RRX_RESP_SLVERR;
        endcase
      end
    end
    // bus read
    if (st_r.rvalid && axi_req.rready) begin
      nxt.rvalid = 1'b0;
    end
    if (axi_req.arvalid && axi_rsp.arready) begin
      nxt.rvalid = 1'b1;
      nxt.rresp = `RRX_RESP_OKAY;
      case (axi_req.araddr)
        `RRX_CTRL_OFS: rd = {30'h0000_0000, st_r.unsup, st_r.phase != RRX_IDLE};
        `RRX_INSTR_OFS: rd = {16'h0000, st_r.instr};
        `RRX_ACC_OFS: rd = {24'h00_0000, st_r.w};
        `RRX_FLAGS_OFS: rd = {27'h000_0000, st_r.flags};
        `RRX_BANK_OFS: rd = {28'h000_0000, st_r.bank};
        `RRX_SHADOW_OFS: rd = {12'h000, st_r.bnkc, 3'h0, st_r.flgc, st_r.accc};
        `RRX_PC_OFS: rd = {11'h000, st_r.pc};
        `RRX_LATCH_OFS: rd = {19'h0_0000, st_r.latu, st_r.lath};
        `RRX_RESULT_OFS: rd = {24'h00_0000, st_r.res};
        default: nxt.rresp = `RRX_RESP_SLVERR;
      endcase
      nxt.rdata = rd;
    end
    // instruction sequencer, one state per instruction cycle, q steps through its four quarters
    case (st_r.phase)
      RRX_IDLE: begin
        if (go) begin
          nxt.phase = RRX_EXEC;
          nxt.q = 2'h0;
          nxt.unsup = 1'b0;
        end
      end
      RRX_EXEC: begin
        nxt.q = st_r.q + 2'h1;
        case (st_r.q)
          2'h0: begin
            nxt.kind = dec;
            nxt.dsel = st_r.instr[9];
            nxt.asel = st_r.instr[8];
            nxt.fadr = st_r.instr[7:0];
            nxt.sopt = st_r.instr[0];
            if (rrx_is_rot(dec)) begin
              nxt.mem.re = 1'b1;
              // access bank is bank 0 for low f, top bank for high f
              nxt.mem.addr = st_r.instr[8] ? {st_r.bank, st_r.instr[7:0]}
                                           : {{4{st_r.instr[7]}}, st_r.instr[7:0]};
            end
          end
          2'h1: begin
            nxt.mem.re = 1'b0;
            if (is_rot) begin
              nxt.opnd = mem_rdata;
            end
          end
          2'h2: begin
            if (is_rot) begin
              nxt.res = rot_res;
              nxt.cout = rot_cout;
              nxt.mem.we = st_r.dsel;
              nxt.mem.wdata = rot_res;
            end
          end
          default: begin
            // accumulator and flags land on one edge, so a bus read never sees half a result
            nxt.mem.we = 1'b0;
            nxt.phase = RRX_IDLE;
            if (is_rot) begin
              if (!st_r.dsel) begin
                nxt.w = st_r.res;
              end
              nxt.flags[`RRX_FLG_N] = st_r.res[7];
              nxt.flags[`RRX_FLG_Z] = (st_r.res == 8'h00);
              if ((st_r.kind == RRX_K_RLC) || (st_r.kind == RRX_K_RRC)) begin
                nxt.flags[`RRX_FLG_C] = st_r.cout;
              end
            end else if (st_r.kind == RRX_K_RET) begin
              nxt.pc = return_stack_head;
              nxt.pop = 1'b1;
              nxt.phase = RRX_REFILL;
              if (st_r.sopt) begin
                nxt.w = st_r.accc;
                nxt.flags = st_r.flgc;
                nxt.bank = st_r.bnkc;
              end
            end else begin
              nxt.unsup = 1'b1;
            end
          end
        endcase
      end
      RRX_REFILL: begin
        // second cycle only counts quarters, nothing is fetched or written
        nxt.q = st_r.q + 2'h1;
        if (st_r.q == `RRX_Q_LAST) begin
          nxt.phase = RRX_IDLE;
        end
      end
      default: nxt.phase = RRX_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic q3_rot;
  logic start_rot;
  logic start_ret;
  assign q3_rot = (st_r.phase == RRX_EXEC) && (st_r.q == 2'h2) && is_rot;
  assign start_rot = go && rrx_is_rot(dec);
  assign start_ret = go && (dec == RRX_K_RET);
  logic q4_plain;
  assign q4_plain = (st_r.phase == RRX_EXEC) && (st_r.q == 2'h3)
    && ((st_r.kind == RRX_K_RLN) || (st_r.kind == RRX_K_RRN));

  sequence s_q3(rrx_kind_e k);
    (st_r.phase == RRX_EXEC) && (st_r.q == 2'h2) && (st_r.kind == k);
  endsequence
  sequence s_q4(rrx_kind_e k);
    (st_r.phase == RRX_EXEC) && (st_r.q == 2'h3) && (st_r.kind == k);
  endsequence
  sequence s_exec4;
    (st_r.phase == RRX_EXEC)[*4];
  endsequence
  sequence s_refill4;
    (st_r.phase == RRX_REFILL && !st_r.mem.we && !st_r.mem.re)[*4];
  endsequence

  ret_pc_load_a: assert property (s_q4(RRX_K_RET) |=>
    st_r.pc == $past(return_stack_head) && stack_pop ##1 !stack_pop)
    else $error("return did not load pc from stack head");
  ret_restore_a: assert property (s_q4(RRX_K_RET) ##0 st_r.sopt |=>
    st_r.w == $past(st_r.accc) && st_r.flags == $past(st_r.flgc) && st_r.bank == $past(st_r.bnkc))
    else $error("return with option did not restore copies");
  ret_keep_a: assert property (s_q4(RRX_K_RET) ##0 !st_r.sopt |=>
    $stable(st_r.w) && $stable(st_r.flags) && $stable(st_r.bank))
    else $error("plain return changed working registers");
  latch_keep_a: assert property (s_q4(RRX_K_RET) |=>
    $stable(st_r.latu) && $stable(st_r.lath))
    else $error("return changed pc latches");
  rlc_rot_a: assert property (s_q3(RRX_K_RLC) |=>
    st_r.res == {$past(st_r.opnd[6:0]), $past(st_r.flags[`RRX_FLG_C])}
    ##1 st_r.flags[`RRX_FLG_C] == $past(st_r.opnd[7], 2))
    else $error("left rotate via carry wrong");
  rln_rot_a: assert property (s_q3(RRX_K_RLN) |=>
    st_r.res == {$past(st_r.opnd[6:0]), $past(st_r.opnd[7])} ##1 $stable(st_r.flags[`RRX_FLG_C]))
    else $error("plain left rotate wrong");
  rrc_rot_a: assert property (s_q3(RRX_K_RRC) |=>
    st_r.res == {$past(st_r.flags[`RRX_FLG_C]), $past(st_r.opnd[7:1])}
    ##1 st_r.flags[`RRX_FLG_C] == $past(st_r.opnd[0], 2))
    else $error("right rotate via carry wrong");
  rrn_rot_a: assert property (s_q3(RRX_K_RRN) |=>
    st_r.res == {$past(st_r.opnd[0]), $past(st_r.opnd[7:1])} ##1 $stable(st_r.flags[`RRX_FLG_C]))
    else $error("plain right rotate wrong");
  dest_sel_a: assert property (q3_rot |=>
    mem.we == st_r.dsel && mem.wdata == st_r.res ##1 !mem.we && (st_r.dsel ? $stable(st_r.w) : st_r.w == $past(st_r.res)))
    else $error("rotate destination wrong");
  bank_sel_a: assert property ((st_r.phase == RRX_EXEC) && (st_r.q == 2'h1) && is_rot |->
    mem.re && mem.addr == (st_r.asel ? {st_r.bank, st_r.fadr} : {{4{st_r.fadr[7]}}, st_r.fadr}))
    else $error("rotate operand bank wrong");
  flag_upd_a: assert property (q3_rot ##1 1'b1 |=>
    st_r.flags[`RRX_FLG_N] == $past(st_r.res[7]) && st_r.flags[`RRX_FLG_Z] == ($past(st_r.res) == 8'h00)
    && $stable(st_r.flags[`RRX_FLG_DC]) && $stable(st_r.flags[`RRX_FLG_OV]))
    else $error("rotate flags wrong");
  rot_len_a: assert property (start_rot |=> s_exec4 ##1 st_r.phase == RRX_IDLE)
    else $error("rotate did not take one cycle");
  ret_len_a: assert property (start_ret |=> s_exec4 ##1 s_refill4 ##1 st_r.phase == RRX_IDLE)
    else $error("return did not take two cycles");
  // carry must survive plain rotates although the flag word is rewritten in Q4
  plain_carry_a: assert property (q4_plain |=> $stable(st_r.flags[`RRX_FLG_C]))
    else $error("plain rotate changed carry");
  pop_only_ret_a: assert property (stack_pop |->
    $past((st_r.phase == RRX_EXEC) && (st_r.q == 2'h3) && (st_r.kind == RRX_K_RET)))
    else $error("stack popped outside a return");
  // a stale kind in Q1 is harmless here, both strobes are low in that quarter
  ret_no_mem_a: assert property ((st_r.phase == RRX_EXEC) && (st_r.kind == RRX_K_RET) |->
    !mem.re && !mem.we)
    else $error("return touched data memory");
  wr_addr_keep_a: assert property (q3_rot |=> $stable(mem.addr))
    else $error("rotate wrote another address than it read");

endmodule

// *** hw/rrx_cfg.svh ***
// constants for the return and rotate execution block: offsets, fields, opcodes
// assumes a 25 MHz core clock where four clocks form one instruction cycle
// Overview of operation
// - return pops stack head into program counter
// - option one restores accumulator, flags, bank pointer
// - option zero leaves those working registers alone
// - return never touches the pc latches
// - left via carry: bit7 to carry, carry in
// - left plain: bit7 wraps to bit0, carry kept
// - right via carry: bit0 to carry, carry in
// - right plain: bit0 wraps to bit7, carry kept
// - destination bit zero selects accumulator, one operand
// - bank bit zero access bank, one bank pointer
// - via-carry rotates update carry, negative, zero
// - plain rotates update negative and zero only
`ifndef RRX_CFG_SVH
`define RRX_CFG_SVH

`define RRX_CTRL_OFS 8'h00
`define RRX_INSTR_OFS 8'h04
`define RRX_ACC_OFS 8'h08
`define RRX_FLAGS_OFS 8'h0C
`define RRX_BANK_OFS 8'h10
`define RRX_SHADOW_OFS 8'h14
`define RRX_PC_OFS 8'h18
`define RRX_LATCH_OFS 8'h1C
`define RRX_RESULT_OFS 8'h20

`define RRX_CTRL_START 0
`define RRX_CTRL_BUSY 0
`define RRX_CTRL_UNSUP 1
`define RRX_SHD_FLG_LSB 8
`define RRX_SHD_BNK_LSB 16
`define RRX_LAT_UP_LSB 8

`define RRX_FLG_C 0
`define RRX_FLG_DC 1
`define RRX_FLG_Z 2
`define RRX_FLG_OV 3
`define RRX_FLG_N 4

`define RRX_OP_RET_HI 15'h0009
`define RRX_OP_RLC 6'h0D
`define RRX_OP_RLN 6'h11
`define RRX_OP_RRC 6'h0C
`define RRX_OP_RRN 6'h10

`define RRX_Q_LAST 2'h3
`define RRX_RESP_OKAY 2'h0
`define RRX_RESP_SLVERR 2'h2
`define RRX_RST_WORD 32'h0000_0000

`endif

// *** hw/rrx_pkg.sv ***
// types shared by the return and rotate execution block
// assumes the constants header is included by each user
package rrx_pkg;

  typedef enum logic [1:0] {
    RRX_IDLE = 2'b00,
    RRX_EXEC = 2'b01,
    RRX_REFILL = 2'b11
  } rrx_phase_e;

  typedef enum logic [2:0] {
    RRX_K_NONE = 3'd0,
    RRX_K_RLC = 3'd1,
    RRX_K_RLN = 3'd2,
    RRX_K_RRC = 3'd3,
    RRX_K_RRN = 3'd4,
    RRX_K_RET = 3'd5
  } rrx_kind_e;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } rrx_mem_s;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } rrx_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } rrx_axi_rsp_s;

  typedef struct packed {
    rrx_phase_e phase;
    logic [1:0] q;
    rrx_kind_e kind;
    logic dsel;
    logic asel;
    logic [7:0] fadr;
    logic sopt;
    logic [7:0] opnd;
    logic [7:0] res;
    logic cout;
    logic [7:0] w;
    logic [4:0] flags;
    logic [3:0] bank;
    logic [7:0] accc;
    logic [4:0] flgc;
    logic [3:0] bnkc;
    logic [20:0] pc;
    logic [4:0] latu;
    logic [7:0] lath;
    logic [15:0] instr;
    rrx_mem_s mem;
    logic pop;
    logic unsup;
    logic aw_got;
    logic [7:0] aw_a;
    logic w_got;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rrx_state_s;

endpackage

// *** hw/rrx_rotate.sv ***
// one-bit rotate of a data byte, left or right, through carry or plain
// assumes operand and carry are stable registers of the caller
`timescale 1ns/1ps
module rrx_rotate (
  input wire logic [7:0] opnd, // operand byte
  input wire logic carry_in, // carry before the rotate
  input rrx_pkg::rrx_kind_e kind, // which rotate
  output logic [7:0] result, // rotated byte
  output logic carry_out // bit leaving the byte
);
  import rrx_pkg::*;

  logic left;
  logic via;
  logic [9:0] ext;

  assign left = (kind == RRX_K_RLC) || (kind == RRX_K_RLN);
  assign via = (kind == RRX_K_RLC) || (kind == RRX_K_RRC);
  // ext puts the incoming bit at both ends so every bit is one mux
  assign ext = {via ? carry_in : opnd[0], opnd, via ? carry_in : opnd[7]};
  assign carry_out = left ? opnd[7] : opnd[0];

  for (genvar i = 0; i < 8; i++) begin : g_bit
    assign result[i] = left ? ext[i] : ext[i + 2];
  end

endmodule

// *** verification/tb_return_and_rotate_exec.sv ***
// self-checking bench for the return and rotate execution block
// assumes the design files and the constants header are on the include path
`timescale 1ns/1ps
`include "rrx_cfg.svh"
module tb_return_and_rotate_exec;
  import rrx_pkg::*;
  logic clk;
  logic rst_b;
  rrx_axi_req_s axi_req;
  rrx_axi_rsp_s axi_rsp;
  logic [20:0] return_stack_head;
  logic stack_pop;
  rrx_mem_s mem;
  logic [7:0] mem_rdata;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int b_cyc = 0;
  int pop_cyc = 0;
  int re_cyc = 0;
  int we_cyc = 0;
  int n_pop = 0;
  int n_we = 0;
  logic [11:0] re_addr;
  logic [11:0] we_addr;
  logic [7:0] we_data;
  logic [1:0] resp;
  logic [31:0] rd;
  logic [5:0] ops [4] = '{`RRX_OP_RLC, `RRX_OP_RLN, `RRX_OP_RRC, `RRX_OP_RRN};

  rrx_exec dut_u (
    .clk(clk),
    .rst_b(rst_b),
    .axi_req(axi_req),
    .axi_rsp(axi_rsp),
    .return_stack_head(return_stack_head),
    .stack_pop(stack_pop),
    .mem(mem),
    .mem_rdata(mem_rdata)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////
  // monitor: cycle stamps of pops and memory strobes
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (stack_pop === 1'b1) begin
      pop_cyc = cyc;
      n_pop++;
    end
    if (mem.re === 1'b1) begin
      re_cyc = cyc;
      re_addr = mem.addr;
    end
    if (mem.we === 1'b1) begin
      we_cyc = cyc;
      we_addr = mem.addr;
      we_data = mem.wdata;
      n_we++;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0d ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////
  // axi4-lite master; bready and rready stay high the whole run
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit done;
    done = 1'b0;
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge clk);
      if (axi_req.awvalid && axi_rsp.awready === 1'b1) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready === 1'b1) axi_req.wvalid <= 1'b0;
      if (axi_rsp.bvalid === 1'b1) begin
        resp = axi_rsp.bresp;
        b_cyc = cyc;
        done = 1'b1;
      end
    end
    if (!done) n_mismatch++;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    bit done;
    done = 1'b0;
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge clk);
      if (axi_req.arvalid && axi_rsp.arready === 1'b1) axi_req.arvalid <= 1'b0;
      if (axi_rsp.rvalid === 1'b1) begin
        rd = axi_rsp.rdata;
        resp = axi_rsp.rresp;
        done = 1'b1;
      end
    end
    if (!done) n_mismatch++;
  endtask

  task automatic wait_idle;
    for (int i = 0; i < 20; i++) begin
      axi_rd(`RRX_CTRL_OFS);
      if (rd[0] === 1'b0) break;
    end
    if (rd[0] !== 1'b0) n_mismatch++;
  endtask

  // returns {carry after, result}; plain rotates hand the old carry back
  function automatic logic [8:0] rot(input logic [5:0] op, input logic [7:0] o, input logic c);
    case (op)
      `RRX_OP_RLC: rot = {o[7], o[6:0], c};
      `RRX_OP_RLN: rot = {c, o[6:0], o[7]};
      `RRX_OP_RRC: rot = {o[0], c, o[7:1]};
      default: rot = {c, o[0], o[7:1]};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////
  task automatic test_map;
    axi_rd(8'h24);
    check(resp, `RRX_RESP_SLVERR);
    check(rd, 32'h0);
    axi_wr(`RRX_RESULT_OFS, 32'hFF);
    check(resp, `RRX_RESP_SLVERR);
    // an undecoded word must flag itself and still finish
    axi_wr(`RRX_INSTR_OFS, 32'h0000_FFFF);
    axi_wr(`RRX_CTRL_OFS, 32'h1);
    wait_idle;
    check(rd, 32'h2);
    $display("test map done");
  endtask

  task automatic test_rotates;
    logic [7:0] opnds [8] = '{8'hE6, 8'hAB, 8'h01, 8'hD7, 8'h80, 8'h00, 8'h01, 8'h00};
    logic [5:0] op;
    logic [7:0] f;
    logic [8:0] e;
    logic [11:0] ea;
    logic d;
    logic a;
    logic c;
    int w0;
    for (int i = 0; i < 8; i++) begin
      op = ops[i % 4];
      d = i[2];
      a = i[0];
      c = i[1];
      f = (i < 4) ? 8'h25 : 8'hA5;
      e = rot(op, opnds[i], c);
      ea = a ? {4'h3, f} : {{4{f[7]}}, f};
      mem_rdata <= opnds[i];
      axi_wr(`RRX_ACC_OFS, 32'h5A);
      // dc and ov preset so any stray update shows
      axi_wr(`RRX_FLAGS_OFS, {27'h0, 4'b0101, c});
      axi_wr(`RRX_BANK_OFS, 32'h3);
      axi_wr(`RRX_INSTR_OFS, {16'h0, op, d, a, f});
      w0 = n_we;
      axi_wr(`RRX_CTRL_OFS, 32'h1);
      wait_idle;
      check(re_addr, ea);
      check(re_cyc - b_cyc, 1);
      check(n_we - w0, d);
      if (d) begin
        check(we_addr, ea);
        check(we_data, e[7:0]);
        check(we_cyc - b_cyc, 3);
      end
      axi_rd(`RRX_RESULT_OFS);
      check(rd, e[7:0]);
      axi_rd(`RRX_ACC_OFS);
      check(rd, d ? 32'h5A : e[7:0]);
      axi_rd(`RRX_FLAGS_OFS);
      check(rd, {e[7], 1'b1, e[7:0] == 8'h00, 1'b1, e[8]});
    end
    $display("test rotates done");
  endtask

  task automatic test_return(input logic s);
    logic [20:0] h;
    int p0;
    int w0;
    int b0;
    h = s ? 21'h1A_BCDE : 21'h05_4321;
    return_stack_head <= h;
    axi_wr(`RRX_ACC_OFS, 32'h11);
    axi_wr(`RRX_FLAGS_OFS, 32'h05);
    axi_wr(`RRX_BANK_OFS, 32'h2);
    axi_wr(`RRX_SHADOW_OFS, 32'h000C_1AC3);
    axi_wr(`RRX_LATCH_OFS, 32'h0000_15A7);
    axi_wr(`RRX_PC_OFS, 32'h0);
    axi_wr(`RRX_INSTR_OFS, {16'h0, 15'h0009, s});
    p0 = n_pop;
    w0 = n_we;
    axi_wr(`RRX_CTRL_OFS, 32'h1);
    b0 = b_cyc;
    // a write landing mid-return must be refused
    axi_wr(`RRX_ACC_OFS, 32'h77);
    check(resp, `RRX_RESP_SLVERR);
    axi_rd(`RRX_CTRL_OFS);
    check(rd[0], 1'b1);
    wait_idle;
    check(n_pop - p0, 1);
    check(pop_cyc - b0, 4);
    check(n_we - w0, 0);
    axi_rd(`RRX_PC_OFS);
    check(rd, {11'h0, h});
    axi_rd(`RRX_LATCH_OFS);
    check(rd, 32'h0000_15A7);
    axi_rd(`RRX_ACC_OFS);
    check(rd, s ? 32'hC3 : 32'h11);
    axi_rd(`RRX_FLAGS_OFS);
    check(rd, s ? 32'h1A : 32'h05);
    axi_rd(`RRX_BANK_OFS);
    check(rd, s ? 32'hC : 32'h2);
    $display("test return option %0d done", s);
  endtask

  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    axi_req = '0;
    axi_req.bready = 1'b1;
    axi_req.rready = 1'b1;
    return_stack_head = '0;
    mem_rdata = '0;
    rst_b = 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    test_map;
    test_rotates;
    test_return(1'b0);
    test_return(1'b1);
    report_and_stop;
  end

  // whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop;
  end
endmodule
